// file: design/citu_top.sv
// interrupt, trap and nonmaskable control of the cpu core
`default_nettype none
module citu_top (
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	// external request pins, active low, asynchronous
	input wire logic [3:0] request_line_n_in,
	input wire logic nmi_n_in,
	// sequencer status
	input wire logic boundary_in,
	input wire logic extended_mode_in,
	input wire logic [31:0] pc_in,
	input wire logic [31:0] sp_in,
	input wire logic fetch_undef_in,
	input wire logic [31:0] insn_start_in,
	// acknowledge completion from the bus unit
	input wire logic ack_done_in,
	input wire logic [15:0] ack_vector_in,
	input wire logic vector_undef_in,
	// decoded instructions
	input wire logic unmask_instruction_in,
	input wire logic mask_off_op_in,
	input wire logic [3:0] op_line_sel_in,
	input wire logic return_from_nmi_op_in,
	input wire logic return_from_service_op_in,
	input wire logic op_read_ivec_in,
	input wire logic op_set_mode_in,
	input wire logic [1:0] op_mode_in,
	input wire logic op_load_ivec_in,
	input wire logic [7:0] ivec_data_in,
	input wire logic op_load_vhigh_in,
	input wire logic [15:0] vhigh_data_in,
	// on-chip i/o access
	input wire logic [7:0] io_addr_in,
	input wire logic io_wr_in,
	input wire logic io_rd_in,
	input wire logic [7:0] io_wdata_in,
	output logic [7:0] io_rdata_out,
	// acknowledge transaction
	output logic ack_active_out,
	output logic [31:0] ack_addr_out,
	// service orders to the sequencer
	output logic svc_valid_out,
	output logic push_en_out,
	output logic [31:0] push_pc_out,
	output logic push_long_out,
	output logic [31:0] new_sp_out,
	output logic jump_en_out,
	output logic [31:0] jump_addr_out,
	output logic table_en_out,
	output logic [31:0] table_addr_out,
	output logic table_long_out,
	output logic exec_en_out,
	output logic [7:0] exec_op_out,
	// flags
	output logic pv_load_out,
	output logic pv_value_out,
	output logic global_enable_flag_out,
	output logic saved_enable_flag_out,
	output logic [7:0] ivec_out,
	output logic [15:0] vector_high_word_out
);
	typedef enum logic [0:0] {ST_IDLE, ST_ACK} citu_state_t;

	citu_arb_if arb ();
	citu_arbiter u_arb (.arb(arb));

	// synchronisers: line 0..3 and nmi on bit 4
	logic [4:0] pin_raw;
	logic [4:0] pin_s1_q;
	logic [4:0] pin_s2_q;
	logic [4:0] pin_s3_q;
	logic [4:0] pin_stable_q;
	assign pin_raw = {nmi_n_in, request_line_n_in};

	genvar gi;
	generate
		for (gi = 0; gi < 5; gi++) begin : g_sync
			always_ff @(posedge clk_in) begin
				if (rst_in) begin
					pin_s1_q[gi] <= 1'b1;
					pin_s2_q[gi] <= 1'b1;
					pin_s3_q[gi] <= 1'b1;
					pin_stable_q[gi] <= 1'b1;
				end else if (ce_in) begin
					pin_s1_q[gi] <= pin_raw[gi];
					pin_s2_q[gi] <= pin_s1_q[gi];
					pin_s3_q[gi] <= pin_s2_q[gi];
					if (pin_s2_q[gi] == pin_s3_q[gi]) begin
						pin_stable_q[gi] <= pin_s3_q[gi];
					end
				end
			end
		end
	endgenerate

	citu_state_t state_q;
	citu_state_t state_d;
	citu_pkg::citu_src_t ack_src_q;
	logic global_q;
	logic saved_q;
	logic [3:0] line_enable_bits_q;
	logic [6:0] base_high_bits_q;
	logic fetch_trap_flag_q;
	logic vector_trap_flag_q;
	logic [7:0] ivec_q;
	logic [15:0] vhigh_q;
	logic [1:0] imode_q;
	logic [1:0] ei_shadow_q;
	logic nmi_pend_q;
	logic fetch_trap_pend_q;
	logic [31:0] trap_start_q;

	// service decision
	logic take;
	logic svc_d;
	logic push_d;
	logic [31:0] push_pc_d;
	logic jump_d;
	logic [31:0] jump_addr_d;
	logic tbl_d;
	logic [31:0] tbl_addr_d;
	logic exec_d;
	logic ev_fetch_trap;
	logic ev_vec_trap;
	logic ev_nmi;
	logic ev_mask;
	logic nmi_fall;
	logic [8:0] avec;
	logic [31:0] push_step;
	logic [3:0] grant_line_n;

	assign nmi_fall = pin_stable_q[4] & ~pin_s3_q[4] & ~pin_s2_q[4];
	assign arb.trap_req = fetch_trap_pend_q;
	assign arb.nmi_req = nmi_pend_q;
	// maskable lines need global, per-line enable, and no enable shadow
	assign arb.line_req = ~pin_stable_q[3:0] & line_enable_bits_q
		& {4{global_q & (ei_shadow_q == 2'h0)}};
	assign take = (state_q == ST_IDLE) & arb.grant_valid
		& (boundary_in | (arb.grant_src == citu_pkg::SRC_TRAP));
	assign push_step = extended_mode_in ? citu_pkg::PUSH_BYTES_EXT
		: citu_pkg::PUSH_BYTES_NATIVE;

	always_comb begin
		unique case (ack_src_q)
			citu_pkg::SRC_LINE2: avec = citu_pkg::AVEC_LINE2;
			citu_pkg::SRC_LINE3: avec = citu_pkg::AVEC_LINE3;
			default: avec = citu_pkg::AVEC_LINE1;
		endcase
	end

	// granted line shown low on the lowest address nibble
	always_comb begin
		unique case (arb.grant_src)
			citu_pkg::SRC_LINE1: grant_line_n = 4'hD;
			citu_pkg::SRC_LINE2: grant_line_n = 4'hB;
			citu_pkg::SRC_LINE3: grant_line_n = 4'h7;
			default: grant_line_n = 4'hE;
		endcase
	end

	always_comb begin
		state_d = state_q;
		svc_d = 1'b0;
		push_d = 1'b0;
		push_pc_d = pc_in;
		jump_d = 1'b0;
		jump_addr_d = citu_pkg::TRAP_ADDR;
		tbl_d = 1'b0;
		tbl_addr_d = 32'h00000000;
		exec_d = 1'b0;
		ev_fetch_trap = 1'b0;
		ev_vec_trap = 1'b0;
		ev_nmi = 1'b0;
		ev_mask = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				if (take) begin
					unique case (arb.grant_src)
						citu_pkg::SRC_TRAP: begin
							svc_d = 1'b1;
							push_d = 1'b1;
							push_pc_d = trap_start_q;
							jump_d = 1'b1;
							jump_addr_d = citu_pkg::TRAP_ADDR;
							ev_fetch_trap = 1'b1;
						end
						citu_pkg::SRC_NMI: begin
							svc_d = 1'b1;
							push_d = 1'b1;
							jump_d = 1'b1;
							jump_addr_d = citu_pkg::NMI_ADDR;
							ev_nmi = 1'b1;
						end
						default: begin
							ev_mask = 1'b1;
							state_d = ST_ACK;
						end
					endcase
				end
			end
			ST_ACK: begin
				if (ack_done_in) begin
					state_d = ST_IDLE;
					svc_d = 1'b1;
					push_d = 1'b1;
					if (ack_src_q != citu_pkg::SRC_LINE0) begin
						tbl_d = 1'b1;
						tbl_addr_d = {vhigh_q, base_high_bits_q, avec};
					end else begin
						unique case (imode_q)
							2'h0: begin
								if (vector_undef_in) begin
									jump_d = 1'b1;
									ev_vec_trap = 1'b1;
								end else begin
									push_d = 1'b0;
									exec_d = 1'b1;
								end
							end
							2'h1: begin
								jump_d = 1'b1;
								jump_addr_d = citu_pkg::MODE1_ADDR;
							end
							2'h2: begin
								tbl_d = 1'b1;
								tbl_addr_d = {vhigh_q, ivec_q, ack_vector_in[15:8]};
							end
							2'h3: begin
								tbl_d = 1'b1;
								tbl_addr_d = {vhigh_q, ack_vector_in};
							end
						endcase
					end
				end
			end
		endcase
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_q <= ST_IDLE;
			ack_src_q <= citu_pkg::SRC_LINE0;
		end else if (ce_in) begin
			state_q <= state_d;
			if (ev_mask) begin
				ack_src_q <= arb.grant_src;
			end
		end
	end

	// service order outputs, one-cycle pulses with held data
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			svc_valid_out <= 1'b0;
			push_en_out <= 1'b0;
			push_pc_out <= 32'h00000000;
			push_long_out <= 1'b0;
			new_sp_out <= 32'h00000000;
			jump_en_out <= 1'b0;
			jump_addr_out <= citu_pkg::TRAP_ADDR;
			table_en_out <= 1'b0;
			table_addr_out <= 32'h00000000;
			table_long_out <= 1'b0;
			exec_en_out <= 1'b0;
			exec_op_out <= 8'h00;
		end else if (ce_in) begin
			svc_valid_out <= svc_d;
			push_en_out <= push_d;
			jump_en_out <= jump_d;
			table_en_out <= tbl_d;
			exec_en_out <= exec_d;
			if (svc_d) begin
				push_pc_out <= extended_mode_in ? push_pc_d
					: {16'h0000, push_pc_d[15:0]};
				push_long_out <= extended_mode_in;
				if (extended_mode_in) begin
					new_sp_out <= sp_in - push_step;
				end else begin
					new_sp_out <= {sp_in[31:16], sp_in[15:0] - push_step[15:0]};
				end
				jump_addr_out <= jump_addr_d;
				table_addr_out <= tbl_addr_d;
				table_long_out <= extended_mode_in;
				exec_op_out <= ack_vector_in[15:8];
			end
		end
	end

	// acknowledge address
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ack_active_out <= 1'b0;
			ack_addr_out <= 32'hFFFFFFFF;
		end else if (ce_in) begin
			ack_active_out <= (state_d == ST_ACK);
			if (ev_mask) begin
				ack_addr_out <= {citu_pkg::ACK_ADDR_HIGH, grant_line_n};
			end else if (state_d == ST_IDLE) begin
				ack_addr_out <= 32'hFFFFFFFF;
			end
		end
	end

	// nonmaskable edge latch, set wins
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			nmi_pend_q <= 1'b0;
		end else if (ce_in) begin
			if (nmi_fall) begin
				nmi_pend_q <= 1'b1;
			end else if (ev_nmi) begin
				nmi_pend_q <= 1'b0;
			end
		end
	end

	// fetch trap capture, live from reset release
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fetch_trap_pend_q <= 1'b0;
			trap_start_q <= 32'h00000000;
		end else if (ce_in) begin
			if (fetch_undef_in) begin
				fetch_trap_pend_q <= 1'b1;
				trap_start_q <= insn_start_in;
			end else if (ev_fetch_trap) begin
				fetch_trap_pend_q <= 1'b0;
			end
		end
	end

	// enable flags
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			global_q <= 1'b0;
			saved_q <= 1'b0;
			ei_shadow_q <= 2'h0;
		end else if (ce_in) begin
			if (ev_nmi) begin
				saved_q <= global_q;
				global_q <= 1'b0;
			end else if (ev_fetch_trap | ev_vec_trap | ev_mask | mask_off_op_in) begin
				global_q <= 1'b0;
				saved_q <= 1'b0;
			end else if (unmask_instruction_in) begin
				global_q <= 1'b1;
				saved_q <= 1'b1;
			end else if (return_from_nmi_op_in) begin
				global_q <= saved_q;
			end
			if (unmask_instruction_in) begin
				ei_shadow_q <= citu_pkg::EI_SHADOW_COUNT;
			end else if (boundary_in && ei_shadow_q != 2'h0) begin
				ei_shadow_q <= ei_shadow_q - 2'h1;
			end
		end
	end

	// parity flag copy on reading the interrupt register
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			pv_load_out <= 1'b0;
			pv_value_out <= 1'b0;
		end else if (ce_in) begin
			pv_load_out <= op_read_ivec_in;
			if (op_read_ivec_in) begin
				pv_value_out <= saved_q;
			end
		end
	end

	// vector register, high word and mode
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ivec_q <= citu_pkg::IVEC_RST;
			vhigh_q <= citu_pkg::VHIGH_RST;
			imode_q <= citu_pkg::IMODE_RST;
		end else if (ce_in) begin
			if (op_load_ivec_in) begin
				ivec_q <= ivec_data_in;
			end
			if (op_load_vhigh_in) begin
				vhigh_q <= vhigh_data_in;
			end
			if (op_set_mode_in) begin
				imode_q <= op_mode_in;
			end
		end
	end

	// on-chip i/o registers
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			line_enable_bits_q <= citu_pkg::LINE_ENABLE_RST;
			base_high_bits_q <= citu_pkg::AVB_RST;
		end else if (ce_in) begin
			if (io_wr_in && io_addr_in == citu_pkg::ADDR_LINE_ENABLE) begin
				line_enable_bits_q <= io_wdata_in[3:0];
			end else if (unmask_instruction_in) begin
				line_enable_bits_q <= line_enable_bits_q | op_line_sel_in;
			end else if (mask_off_op_in) begin
				line_enable_bits_q <= line_enable_bits_q & ~op_line_sel_in;
			end
			if (io_wr_in && io_addr_in == citu_pkg::ADDR_AVB) begin
				base_high_bits_q <= io_wdata_in[7:1];
			end
		end
	end

	// trap status: hardware set wins over a clearing write
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			fetch_trap_flag_q <= 1'b0;
			vector_trap_flag_q <= 1'b0;
		end else if (ce_in) begin
			if (ev_fetch_trap) begin
				fetch_trap_flag_q <= 1'b1;
			end else if (io_wr_in && io_addr_in == citu_pkg::ADDR_TRAP_STATUS
				&& !io_wdata_in[citu_pkg::FETCH_TRAP_BIT]) begin
				fetch_trap_flag_q <= 1'b0;
			end
			if (ev_vec_trap) begin
				vector_trap_flag_q <= 1'b1;
			end else if (io_wr_in && io_addr_in == citu_pkg::ADDR_TRAP_STATUS
				&& !io_wdata_in[citu_pkg::VECTOR_TRAP_BIT]) begin
				vector_trap_flag_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			io_rdata_out <= 8'h00;
		end else if (ce_in && io_rd_in) begin
			unique case (io_addr_in)
				citu_pkg::ADDR_LINE_ENABLE: io_rdata_out <= {4'h0, line_enable_bits_q};
				citu_pkg::ADDR_AVB: io_rdata_out <= {base_high_bits_q, 1'b0};
				citu_pkg::ADDR_TRAP_STATUS: io_rdata_out <= {6'h00, fetch_trap_flag_q,
					vector_trap_flag_q};
				default: io_rdata_out <= 8'h00;
			endcase
		end
	end

	assign global_enable_flag_out = global_q;
	assign saved_enable_flag_out = saved_q;
	assign ivec_out = ivec_q;
	assign vector_high_word_out = vhigh_q;
endmodule : citu_top
`default_nettype wire

// file: design/citu_pkg.sv
// constants and types shared by the interrupt and trap unit
`default_nettype none
package citu_pkg;
	// on-chip i/o addresses
	localparam logic [7:0] ADDR_LINE_ENABLE = 8'h17;
	localparam logic [7:0] ADDR_AVB = 8'h18;
	localparam logic [7:0] ADDR_TRAP_STATUS = 8'h19;
	// register field positions
	localparam int FETCH_TRAP_BIT = 1;
	localparam int VECTOR_TRAP_BIT = 0;
	localparam int LINE_COUNT = 4;
	// reset values
	localparam logic [3:0] LINE_ENABLE_RST = 4'h0;
	localparam logic [6:0] AVB_RST = 7'h00;
	localparam logic [7:0] IVEC_RST = 8'h00;
	localparam logic [15:0] VHIGH_RST = 16'h0000;
	localparam logic [1:0] IMODE_RST = 2'h0;
	// service addresses
	localparam logic [31:0] TRAP_ADDR = 32'h00000000;
	localparam logic [31:0] NMI_ADDR = 32'h00000066;
	localparam logic [31:0] MODE1_ADDR = 32'h00000038;
	// acknowledge address: upper lines high
	localparam logic [27:0] ACK_ADDR_HIGH = 28'hFFFFFFF;
	// assigned vector offsets for lines 1..3
	localparam logic [8:0] AVEC_LINE1 = 9'h000;
	localparam logic [8:0] AVEC_LINE2 = 9'h004;
	localparam logic [8:0] AVEC_LINE3 = 9'h008;
	// stack step in bytes
	localparam logic [31:0] PUSH_BYTES_NATIVE = 32'h00000002;
	localparam logic [31:0] PUSH_BYTES_EXT = 32'h00000004;
	// instruction boundaries covered by the enable shadow
	localparam logic [1:0] EI_SHADOW_COUNT = 2'h2;
	// pin synchroniser depth
	localparam int SYNC_STAGES = 3;

	typedef enum logic [2:0] {
		SRC_TRAP,
		SRC_NMI,
		SRC_LINE0,
		SRC_LINE1,
		SRC_LINE2,
		SRC_LINE3
	} citu_src_t;
endpackage : citu_pkg
`default_nettype wire

// file: design/citu_arb_if.sv
// request and grant signals between the unit and its priority resolver
`default_nettype none
interface citu_arb_if;
	logic trap_req;
	logic nmi_req;
	logic [3:0] line_req;
	logic grant_valid;
	citu_pkg::citu_src_t grant_src;

	modport requester (output trap_req, output nmi_req, output line_req,
		input grant_valid, input grant_src);
	modport resolver (input trap_req, input nmi_req, input line_req,
		output grant_valid, output grant_src);
endinterface : citu_arb_if
`default_nettype wire

// file: design/citu_arbiter.sv
// fixed priority resolver: trap, nmi, then lines 0..3
`default_nettype none
module citu_arbiter (
	citu_arb_if.resolver arb
);
	always_comb begin
		arb.grant_valid = 1'b1;
		arb.grant_src = citu_pkg::SRC_TRAP;
		if (arb.trap_req) begin
			arb.grant_src = citu_pkg::SRC_TRAP;
		end else if (arb.nmi_req) begin
			arb.grant_src = citu_pkg::SRC_NMI;
		end else if (arb.line_req[0]) begin
			arb.grant_src = citu_pkg::SRC_LINE0;
		end else if (arb.line_req[1]) begin
			arb.grant_src = citu_pkg::SRC_LINE1;
		end else if (arb.line_req[2]) begin
			arb.grant_src = citu_pkg::SRC_LINE2;
		end else if (arb.line_req[3]) begin
			arb.grant_src = citu_pkg::SRC_LINE3;
		end else begin
			arb.grant_valid = 1'b0;
		end
	end
endmodule : citu_arbiter
`default_nettype wire

// file: design/citu_top_fix.sv
// reserved for shared helpers of the unit; holds no logic
`default_nettype none
`default_nettype wire

// file: tb/citu_top_sva.sv
// port assertions for the interrupt and trap unit
`default_nettype none
module citu_top_sva (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// watched inputs
	input wire logic ce_in,
	input wire logic extended_mode_in,
	input wire logic fetch_undef_in,
	input wire logic [31:0] insn_start_in,
	input wire logic ack_done_in,
	input wire logic unmask_instruction_in,
	input wire logic mask_off_op_in,
	input wire logic return_from_nmi_op_in,
	input wire logic op_read_ivec_in,
	input wire logic [7:0] io_addr_in,
	input wire logic io_rd_in,
	// watched outputs
	input wire logic [7:0] io_rdata_out,
	input wire logic ack_active_out,
	input wire logic [31:0] ack_addr_out,
	input wire logic svc_valid_out,
	input wire logic [31:0] push_pc_out,
	input wire logic jump_en_out,
	input wire logic [31:0] jump_addr_out,
	input wire logic pv_load_out,
	input wire logic pv_value_out,
	input wire logic global_enable_flag_out,
	input wire logic saved_enable_flag_out,
	input wire logic [7:0] ivec_out,
	input wire logic [15:0] vector_high_word_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	sequence s_ack_open;
		$rose(ack_active_out);
	endsequence
	sequence s_ack_close;
		ack_active_out && ack_done_in && ce_in;
	endsequence
	ack_addr_a: assert property (
		ack_active_out |-> ack_addr_out[31:4] == citu_pkg::ACK_ADDR_HIGH
		&& ack_addr_out[3:0] inside {4'hE, 4'hD, 4'hB, 4'h7})
		else $error("acknowledge address malformed");
	ack_gated_a: assert property (
		s_ack_open |-> $past(global_enable_flag_out))
		else $error("acknowledge started with global enable clear");
	ack_clears_a: assert property (
		s_ack_open |-> !global_enable_flag_out && !saved_enable_flag_out)
		else $error("enable flags not cleared on maskable accept");
	ack_close_a: assert property (
		s_ack_close |=> svc_valid_out && !ack_active_out)
		else $error("no service order after acknowledge");
	trap_jump_a: assert property (
		fetch_undef_in && ce_in && !ack_active_out |-> ##2 svc_valid_out
		&& jump_addr_out == citu_pkg::TRAP_ADDR
		&& push_pc_out[15:0] == $past(insn_start_in[15:0], 2)
		&& push_pc_out[31:16] == ($past(extended_mode_in)
		? $past(insn_start_in[31:16], 2) : 16'h0000)
		&& !global_enable_flag_out)
		else $error("trap service wrong");
	nmi_flags_a: assert property (
		svc_valid_out && jump_en_out && jump_addr_out == citu_pkg::NMI_ADDR
		|-> !global_enable_flag_out && saved_enable_flag_out == $past(global_enable_flag_out))
		else $error("nonmaskable flag copy wrong");
	return_from_nmi_op_copy_a: assert property (
		return_from_nmi_op_in && ce_in && !unmask_instruction_in && !mask_off_op_in
		|=> svc_valid_out || $rose(ack_active_out)
		|| global_enable_flag_out == $past(saved_enable_flag_out))
		else $error("saved enable not restored");
	pv_copy_a: assert property (
		op_read_ivec_in && ce_in |=> pv_load_out && pv_value_out == $past(saved_enable_flag_out))
		else $error("parity flag copy wrong");
	ie_rsvd_a: assert property (
		io_rd_in && ce_in && io_addr_in == citu_pkg::ADDR_LINE_ENABLE |=> io_rdata_out[7:4] == 4'h0)
		else $error("line enable upper bits not zero");
	avb_rsvd_a: assert property (
		io_rd_in && ce_in && io_addr_in == citu_pkg::ADDR_AVB |=> io_rdata_out[0] == 1'b0)
		else $error("vector base bit 0 not zero");
	rst_clear_a: assert property (
		$fell(rst_in) |-> ivec_out == citu_pkg::IVEC_RST
		&& vector_high_word_out == citu_pkg::VHIGH_RST)
		else $error("vector registers not cleared by reset");
endmodule : citu_top_sva
bind citu_top citu_top_sva u_citu_top_sva (.clk_in, .rst_in, .ce_in, .extended_mode_in,
	.fetch_undef_in,
	.insn_start_in, .ack_done_in, .unmask_instruction_in, .mask_off_op_in,
	.return_from_nmi_op_in, .op_read_ivec_in, .io_addr_in, .io_rd_in, .io_rdata_out,
	.ack_active_out, .ack_addr_out, .svc_valid_out, .push_pc_out, .jump_en_out,
	.jump_addr_out, .pv_load_out, .pv_value_out, .global_enable_flag_out,
	.saved_enable_flag_out, .ivec_out, .vector_high_word_out);
`default_nettype wire

// file: tb/citu_periph_model.sv
// peripheral side: request pins, nonmaskable pin and acknowledge answers
`default_nettype none
module citu_periph_model (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// orders from the bench
	input wire logic [3:0] raise_in,
	input wire logic nmi_fire_in,
	input wire logic [15:0] vec_in,
	input wire logic bad_in,
	input wire logic [2:0] delay_in,
	// acknowledge from the unit
	input wire logic ack_active_in,
	input wire logic [31:0] ack_addr_in,
	// pins towards the unit
	output logic [3:0] request_line_n_out,
	output logic nmi_n_out,
	output logic ack_done_out,
	output logic [15:0] ack_vector_out,
	output logic vector_undef_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] pend_q;
	logic [2:0] wait_q;
	assign request_line_n_out = ~pend_q;
	// rising edge: bench orders made at the falling edge are settled here
	always @(posedge clk_in) begin
		nmi_n_out <= ~nmi_fire_in;
		if (rst_in) begin
			pend_q <= 4'h0;
			wait_q <= 3'h0;
			ack_done_out <= 1'b0;
			vector_undef_out <= 1'b0;
			ack_vector_out <= 16'hA5C3;
		end else if (ack_active_in && !ack_done_out && wait_q == delay_in) begin
			ack_done_out <= 1'b1;
			ack_vector_out <= vec_in;
			vector_undef_out <= bad_in;
			pend_q <= (pend_q | raise_in) & ack_addr_in[3:0];
			wait_q <= 3'h0;
		end else begin
			ack_done_out <= 1'b0;
			vector_undef_out <= 1'b0;
			// released bus never keeps its last value
			ack_vector_out <= ~ack_vector_out;
			pend_q <= pend_q | raise_in;
			wait_q <= (ack_active_in && !ack_done_out) ? wait_q + 3'h1 : 3'h0;
		end
	end
endmodule : citu_periph_model
`default_nettype wire

// file: tb/cpu_interrupt_trap_unit_tb.sv
// self-checking bench for the interrupt and trap unit
`default_nettype none
module cpu_interrupt_trap_unit_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0, rst_in = 1'b1, boundary_in = 1'b1, extended_mode_in = 1'b0;
	logic fetch_undef_in = 1'b0, io_wr_in = 1'b0, io_rd_in = 1'b0, nmi_fire = 1'b0, bad = 1'b0;
	logic [7:0] ops = 8'h00, io_addr_in = 8'h00, io_wdata_in = 8'h00;
	logic [31:0] r = 32'h0, pc_in = 32'h0, sp_in = 32'h12340000, insn_start_in = 32'h0;
	logic [15:0] vec = 16'h0;
	logic [3:0] raise = 4'h0;
	logic [2:0] delay = 3'h3;
	logic [1:0] op_mode_in = 2'h0;
	logic [3:0] request_line_n_in;
	logic nmi_n_in, ack_done_in, vector_undef_in, ack_active_out, svc_valid_out;
	logic push_long_out, pv_value_out, gie, sie, push_en_out, table_en_out, exec_en_out;
	logic table_long_out;
	logic [3:0] orders;
	logic [15:0] ack_vector_in, vector_high_word_out;
	logic [7:0] io_rdata_out, exec_op_out, ivec_out;
	logic [31:0] ack_addr_out, push_pc_out, new_sp_out, jump_addr_out, table_addr_out;
	int miscompares = 0, n_checks = 0, cyc = 0;
	citu_top u_citu_top (.clk_in, .rst_in, .ce_in(1'b1), .request_line_n_in, .nmi_n_in,
		.boundary_in, .extended_mode_in, .pc_in, .sp_in, .fetch_undef_in, .insn_start_in,
		.ack_done_in, .ack_vector_in, .vector_undef_in, .unmask_instruction_in(ops[0]),
		.mask_off_op_in(ops[1]), .op_line_sel_in(4'hF), .return_from_nmi_op_in(ops[3]),
		.return_from_service_op_in(ops[7]), .op_read_ivec_in(ops[2]), .op_set_mode_in(ops[4]),
		.op_mode_in, .op_load_ivec_in(ops[5]), .ivec_data_in(r[23:16]),
		.op_load_vhigh_in(ops[6]), .vhigh_data_in(r[31:16]), .io_addr_in, .io_wr_in, .io_rd_in,
		.io_wdata_in, .io_rdata_out, .ack_active_out, .ack_addr_out, .svc_valid_out,
		.push_en_out, .push_pc_out, .push_long_out, .new_sp_out, .jump_en_out(),
		.jump_addr_out, .table_en_out, .table_addr_out, .table_long_out, .exec_en_out,
		.exec_op_out, .pv_load_out(), .pv_value_out, .global_enable_flag_out(gie),
		.saved_enable_flag_out(sie), .ivec_out, .vector_high_word_out);
	citu_periph_model u_citu_periph_model (.clk_in, .rst_in, .raise_in(raise),
		.nmi_fire_in(nmi_fire), .vec_in(vec), .bad_in(bad), .delay_in(delay),
		.ack_active_in(ack_active_out), .ack_addr_in(ack_addr_out),
		.request_line_n_out(request_line_n_in), .nmi_n_out(nmi_n_in),
		.ack_done_out(ack_done_in), .ack_vector_out(ack_vector_in),
		.vector_undef_out(vector_undef_in));
	assign orders = {push_en_out, table_en_out, exec_en_out, table_long_out};
	initial begin
		forever #5 clk_in = ~clk_in;
	end
	task automatic wrap_up();
		$display("checks %0d miscompares %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : wrap_up
	always @(posedge clk_in) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			wrap_up();
		end
	end
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic op(input int k);
		ops = 8'h01 << k;
		@(negedge clk_in);
		ops = 8'h00;
		@(negedge clk_in);
	endtask : op
	task automatic io(input logic wr, input logic [7:0] a, input logic [7:0] d);
		{io_wr_in, io_rd_in, io_addr_in, io_wdata_in} = {wr, !wr, a, d};
		@(negedge clk_in);
		{io_wr_in, io_rd_in} = 2'b00;
		@(negedge clk_in);
	endtask : io
	// waits for acknowledge (1) or service order (0)
	task automatic await(input logic ack);
		repeat (300) begin
			@(negedge clk_in);
			fetch_undef_in = 1'b0;
			if (ack ? ack_active_out === 1'b1 : svc_valid_out === 1'b1) return;
		end
		chk("handshake", 1, 0);
	endtask : await
	function automatic logic [31:0] exp_l0(input int m, input logic [15:0] v);
		case (m)
			0: return 32'h00000000;
			1: return {24'h000000, v[15:8]};
			2: return {r[31:16], r[23:16], v[15:8]};
			default: return {r[31:16], v};
		endcase
	endfunction : exp_l0
	function automatic logic [31:0] exp_push(input logic [31:0] v);
		return extended_mode_in ? v : {16'h0000, v[15:0]};
	endfunction : exp_push
	initial begin
		r = $urandom(51738);
		repeat (16) @(negedge clk_in);
		rst_in = 1'b0;
		repeat (4) @(negedge clk_in);
		chk("reset_state", 0, {ivec_out, vector_high_word_out, gie, sie});
		for (int a = 8'h17; a <= 8'h1A; a++) begin
			io(0, a[7:0], 8'h00);
			chk("reset_reg", 0, io_rdata_out);
		end
		r = $urandom;
		io(1, 8'h17, r[7:0]);
		io(1, 8'h18, r[15:8]);
		io(1, 8'h1A, 8'hFF);
		io(0, 8'h17, 8'h00);
		chk("line_enable", {4'h0, r[3:0]}, io_rdata_out);
		io(0, 8'h18, 8'h00);
		chk("vector_base", {r[15:9], 1'b0}, io_rdata_out);
		io(0, 8'h1A, 8'h00);
		chk("unmapped", 0, io_rdata_out);
		op(5);
		op(6);
		chk("vector_regs", {r[23:16], r[31:16]}, {ivec_out, vector_high_word_out});
		// fetch trap while enabled
		op(0);
		chk("enabled", 3, {gie, sie});
		insn_start_in = $urandom;
		pc_in = $urandom;
		fetch_undef_in = 1'b1;
		await(0);
		chk("trap_jump", 0, jump_addr_out);
		chk("trap_push", exp_push(insn_start_in), push_pc_out);
		chk("trap_orders", 4'h8, orders);
		chk("trap_flags", 0, {gie, sie});
		io(0, 8'h19, 8'h00);
		chk("trap_status", 2, io_rdata_out);
		for (int i = 0; i < 2; i++) begin
			io(1, 8'h19, i ? 8'h00 : 8'hFF);
			io(0, 8'h19, 8'h00);
			chk("trap_status", i ? 0 : 2, io_rdata_out);
		end
		// nonmaskable in native mode, latched while no boundary
		op(0);
		boundary_in = 1'b0;
		nmi_fire = 1'b1;
		repeat (4) @(negedge clk_in);
		nmi_fire = 1'b0;
		repeat (4) @(negedge clk_in);
		boundary_in = 1'b1;
		await(0);
		chk("nmi_jump", 32'h00000066, jump_addr_out);
		chk("nmi_push", exp_push(pc_in), push_pc_out);
		chk("nmi_orders", 4'h8, orders);
		chk("native_sp", 32'h1234FFFE, new_sp_out);
		chk("native_size", 0, push_long_out);
		chk("nmi_flags", 1, {gie, sie});
		op(2);
		chk("pv_copy", 1, pv_value_out);
		op(3);
		chk("return_from_nmi_op_flags", 3, {gie, sie});
		op(7);
		chk("return_from_service_op_flags", 3, {gie, sie});
		// all four lines at once, extended mode, line 0 in mode 1
		extended_mode_in = 1'b1;
		sp_in = 32'h00000000;
		op_mode_in = 2'h1;
		op(4);
		boundary_in = 1'b0;
		raise = 4'hF;
		@(negedge clk_in);
		raise = 4'h0;
		repeat (5) @(negedge clk_in);
		boundary_in = 1'b1;
		for (int i = 0; i < 4; i++) begin
			delay = 3'h3 + 3'($urandom % 5);
			if (i > 0) op(0);
			await(1);
			chk("ack_addr", {28'hFFFFFFF, ~(4'h1 << i)}, ack_addr_out);
			await(0);
			chk("target", i ? {r[31:16], r[15:9], 9'(4 * (i - 1))} : 32'h00000038,
				i ? table_addr_out : jump_addr_out);
			chk("ext_sp", 32'hFFFFFFFC, new_sp_out);
			chk("ext_size", 1, push_long_out);
			chk("line_orders", i ? 4'hD : 4'h9, orders);
			chk("line_flags", 0, {gie, sie});
		end
		// line 0 in the other modes: bad vector, mode 0, 2 and 3
		for (int m = 0; m < 4; m++) begin
			op_mode_in = (m == 1) ? 2'h0 : 2'(m);
			bad = (m == 0);
			vec = 16'($urandom);
			op(4);
			op(0);
			raise = 4'h1;
			@(negedge clk_in);
			raise = 4'h0;
			await(0);
			chk("line0_target", exp_l0(m, vec), m == 0 ? jump_addr_out : m == 1 ?
				{24'h000000, exec_op_out} : table_addr_out);
			if (m == 0) chk("vec_trap_push", exp_push(pc_in), push_pc_out);
			chk("l0_orders", m == 0 ? 4'h9 : m == 1 ? 4'h3 : 4'hD, orders);
		end
		io(0, 8'h19, 8'h00);
		chk("vec_trap_flag", 1, io_rdata_out);
		// global enable clear: held request waits
		op(1);
		raise = 4'h2;
		@(negedge clk_in);
		raise = 4'h0;
		repeat (30) begin
			@(negedge clk_in);
			chk("masked", 0, ack_active_out);
		end
		op(0);
		await(1);
		chk("held_ack", 32'hFFFFFFFD, ack_addr_out);
		await(0);
		wrap_up();
	end
endmodule : cpu_interrupt_trap_unit_tb
`default_nettype wire
